// ### logic/multiply_accumulate_unit.sv
`timescale 1ns/100ps
`include "mac_params.svh"

// Contract
// - Multiply two 32-bit register operands into a 32-bit destination.
// - Accumulate form adds addend register to the product.
// - Booth scheme, any multiply finishes within 16 clocks.
// - Stop early when upper bits clear; 16 clear upper bits means 8 clocks.
// - Signed and unsigned operands both give the right low result.
// - Byte values are full 32-bit operands, product in low bits.
// - Flags change only when flag update is requested.
// - Update sets N and Z, C unspecified, V kept.
// - PC as multiplicand keeps status bits, advanced by 12.
// - PC as multiplier drops status bits, advanced by 8.
// - PC as addend keeps status bits, advanced by 8.
// - Plain multiply gives product only, no accumulation.
module multiply_accumulate_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Issue
   input wire logic start,
   input wire mac_pkg::mac_cmd_s cmd,
   input wire mac_pkg::mac_ops_s ops,
   input wire mac_pkg::mac_flags_s flags_in,
   output logic busy,
   // Write back
   output logic done,
   output logic [3:0] dest_reg,
   output logic [31:0] result,
   output logic flags_we,
   output mac_pkg::mac_flags_s flags_out
);

   mac_pkg::mac_state_e state_ff;
   logic [31:0] mcand_sel, mplier_sel, addend_sel;
   logic [31:0] mcand_ff, acc_ff, mplier_ff;
   logic prev_bit_ff;
   logic [4:0] count_ff;
   logic accumulate_ff, set_flags_ff;
   logic [3:0] dest_ff;
   mac_pkg::mac_flags_s flags_hold_ff;
   logic [31:0] pp;
   logic [31:0] nxt_acc;
   logic [31:0] nxt_mplier;
   logic last_step;
   logic swap_ops;
   logic [31:0] mcand_shift, tail_pp, fin_acc;

   // Operand sources, including the program counter cases
   mac_operand_sel u_sel_mcand (
      .reg_num(cmd.multiplicand_reg),
      .keep_status(1'b1),
      .advance(`MAC_PC_ADV_MCAND),
      .reg_value(ops.multiplicand),
      .pc_word(ops.pc_word),
      .operand(mcand_sel)
   );
   mac_operand_sel u_sel_mplier (
      .reg_num(cmd.multiplier_reg),
      .keep_status(1'b0),
      .advance(`MAC_PC_ADV_MPLIER),
      .reg_value(ops.multiplier),
      .pc_word(ops.pc_word),
      .operand(mplier_sel)
   );
   mac_operand_sel u_sel_addend (
      .reg_num(cmd.addend_reg),
      .keep_status(1'b1),
      .advance(`MAC_PC_ADV_ADDEND),
      .reg_value(ops.addend),
      .pc_word(ops.pc_word),
      .operand(addend_sel)
   );

   // Early exit only looks at the multiplier, so a short multiplicand takes
   // the multiplier seat; the low product word does not change
   assign swap_ops = (mplier_sel[31:16] != 16'h0000)
                   && (mcand_sel[31:16] == 16'h0000);

   // Booth recode of the low multiplier bits each clock
   mac_booth_step u_step (
      .triple({mplier_ff[1:0], prev_bit_ff}),
      .mcand(mcand_ff),
      .pp(pp)
   );

   // Shifted multiplier with sign fill so negative values terminate too
   assign nxt_mplier = {{2{mplier_ff[31]}}, mplier_ff[31:2]};
   assign nxt_acc = acc_ff + pp;

   // Stop once the rest of the multiplier is pure sign extension
   assign last_step = (count_ff == 5'(`MAC_MAX_CYCLES - 1))
                    || (nxt_mplier == 32'h00000000)
                    || (nxt_mplier == 32'hffffffff);

   // The one Booth digit still pending at an early exit is folded into the
   // last add, so a 16-bit multiplier with its top bit set ends in 8 steps
   assign mcand_shift = {mcand_ff[29:0], 2'b00};
   mac_booth_step u_tail (
      .triple({nxt_mplier[1:0], mplier_ff[1]}),
      .mcand(mcand_shift),
      .pp(tail_pp)
   );
   assign fin_acc = nxt_acc + tail_pp;

   // Sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= mac_pkg::st_idle;
      end else begin
         case (state_ff)
            mac_pkg::st_idle: if (start) state_ff <= mac_pkg::st_run;
            mac_pkg::st_run: if (last_step) state_ff <= mac_pkg::st_done;
            mac_pkg::st_done: state_ff <= mac_pkg::st_idle;
            default: state_ff <= mac_pkg::st_idle;
         endcase
      end
   end

   // Step counter, bounds the worst case
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= 5'h00;
      end else if (state_ff == mac_pkg::st_idle) begin
         count_ff <= 5'h00;
      end else if (state_ff == mac_pkg::st_run) begin
         count_ff <= count_ff + 5'h01;
      end
   end

   // Datapath: load on issue, accumulate partial products while running
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mcand_ff <= 32'h00000000;
         mplier_ff <= 32'h00000000;
         prev_bit_ff <= 1'b0;
         acc_ff <= 32'h00000000;
      end else if (state_ff == mac_pkg::st_idle && start) begin
         mcand_ff <= swap_ops ? mplier_sel : mcand_sel;
         mplier_ff <= swap_ops ? mcand_sel : mplier_sel;
         prev_bit_ff <= 1'b0;
         // Seeding with the addend saves a final add cycle
         acc_ff <= cmd.accumulate ? addend_sel : 32'h00000000;
      end else if (state_ff == mac_pkg::st_run) begin
         acc_ff <= nxt_acc;
         mcand_ff <= {mcand_ff[29:0], 2'b00};
         mplier_ff <= nxt_mplier;
         prev_bit_ff <= mplier_ff[1];
      end
   end

   // Command fields kept for write back
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accumulate_ff <= 1'b0;
         set_flags_ff <= 1'b0;
         dest_ff <= 4'h0;
         flags_hold_ff <= '0;
      end else if (state_ff == mac_pkg::st_idle && start) begin
         accumulate_ff <= cmd.accumulate;
         set_flags_ff <= cmd.set_flags;
         dest_ff <= cmd.dest_reg;
         flags_hold_ff <= flags_in;
      end
   end

   // Registered write back outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result <= 32'h00000000;
         dest_reg <= 4'h0;
         flags_out <= '0;
      end else if (state_ff == mac_pkg::st_run && last_step) begin
         result <= fin_acc;
         dest_reg <= dest_ff;
         flags_out.n <= fin_acc[31];
         flags_out.z <= (fin_acc == 32'h00000000);
         flags_out.c <= 1'b0; // Carry left as zero; callers must not rely on it
         flags_out.v <= flags_hold_ff.v;
      end
   end

   // Handshake outputs
   assign done = (state_ff == mac_pkg::st_done);
   assign flags_we = done && set_flags_ff;
   assign busy = (state_ff != mac_pkg::st_idle);

   // Reference low product for checks; not used by the datapath
   logic [31:0] ref_mcand, ref_mplier, ref_addend;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_mcand <= 32'h00000000;
         ref_mplier <= 32'h00000000;
         ref_addend <= 32'h00000000;
      end else if (state_ff == mac_pkg::st_idle && start) begin
         ref_mcand <= mcand_sel;
         ref_mplier <= mplier_sel;
         ref_addend <= cmd.accumulate ? addend_sel : 32'h00000000;
      end
   end

   sequence s_issue;
      !busy && start;
   endsequence

   sequence s_short;
      !busy && start && ((mplier_sel[31:16] == 16'h0000) || (mcand_sel[31:16] == 16'h0000)
                         || (mplier_sel[31:15] == 17'h1ffff));
   endsequence

   property p_result_ok;
      @(posedge clk) disable iff (!rstn)
      done |-> result == 32'(ref_mcand * ref_mplier + ref_addend);
   endproperty
   a_result_ok: assert property (p_result_ok) else $error("wrong result");

   property p_worst;
      @(posedge clk) disable iff (!rstn)
      s_issue |-> ##[1:17] done;
   endproperty
   a_worst: assert property (p_worst) else $error("multiply too slow");

   property p_short;
      @(posedge clk) disable iff (!rstn)
      s_short |-> ##[1:9] done;
   endproperty
   a_short: assert property (p_short) else $error("no early exit");

   property p_flags_gate;
      @(posedge clk) disable iff (!rstn)
      flags_we |-> done && set_flags_ff;
   endproperty
   a_flags_gate: assert property (p_flags_gate) else $error("flag write unrequested");

   property p_nz;
      @(posedge clk) disable iff (!rstn)
      done |-> flags_out.n == result[31] && flags_out.z == (result == 32'h00000000);
   endproperty
   a_nz: assert property (p_nz) else $error("bad n or z");

   property p_v_kept;
      @(posedge clk) disable iff (!rstn)
      s_issue ##1 (busy [*1]) ##[0:16] done |-> flags_out.v == flags_hold_ff.v;
   endproperty
   a_v_kept: assert property (p_v_kept) else $error("overflow flag altered");

   property p_plain;
      @(posedge clk) disable iff (!rstn)
      (!busy && start && !cmd.accumulate) |=> acc_ff == 32'h00000000;
   endproperty
   a_plain: assert property (p_plain) else $error("plain multiply accumulated");

   property p_pc_mplier;
      @(posedge clk) disable iff (!rstn)
      (!busy && start && cmd.multiplier_reg == `MAC_PC_REG)
         |-> mplier_sel == ((ops.pc_word + `MAC_PC_ADV_MPLIER) & `MAC_PC_FIELD_MASK);
   endproperty
   a_pc_mplier: assert property (p_pc_mplier) else $error("pc multiplier wrong");

   property p_dest;
      @(posedge clk) disable iff (!rstn)
      s_issue ##1 busy [*1] ##[0:16] done |-> dest_reg == dest_ff;
   endproperty
   a_dest: assert property (p_dest) else $error("wrong destination");

   // Address field advanced by whole words, status bits passed through
   property p_pc_mcand;
      @(posedge clk) disable iff (!rstn)
      (!busy && start && cmd.multiplicand_reg == `MAC_PC_REG)
         |-> mcand_sel[25:2] == 24'(ops.pc_word[25:2] + 24'(`MAC_PC_ADV_MCAND >> 2))
          && mcand_sel[31:26] == ops.pc_word[31:26] && mcand_sel[1:0] == ops.pc_word[1:0];
   endproperty
   a_pc_mcand: assert property (p_pc_mcand) else $error("pc multiplicand wrong");

   property p_pc_addend;
      @(posedge clk) disable iff (!rstn)
      (!busy && start && cmd.accumulate && cmd.addend_reg == `MAC_PC_REG)
         |-> addend_sel[25:2] == 24'(ops.pc_word[25:2] + 24'(`MAC_PC_ADV_ADDEND >> 2))
          && addend_sel[31:26] == ops.pc_word[31:26] && addend_sel[1:0] == ops.pc_word[1:0];
   endproperty
   a_pc_addend: assert property (p_pc_addend) else $error("pc addend wrong");

   property p_busy_run;
      @(posedge clk) disable iff (!rstn)
      s_issue |=> busy;
   endproperty
   a_busy_run: assert property (p_busy_run) else $error("issue not taken");

   property p_done_pulse;
      @(posedge clk) disable iff (!rstn)
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

   property p_steps;
      @(posedge clk) disable iff (!rstn)
      (state_ff == mac_pkg::st_run) |-> count_ff < 5'h10;
   endproperty
   a_steps: assert property (p_steps) else $error("step count past limit");

   property p_result_hold;
      @(posedge clk) disable iff (!rstn)
      !(state_ff == mac_pkg::st_run && last_step) |=> $stable(result);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed");

endmodule

// ### logic/mac_params.svh
`ifndef MAC_PARAMS_SVH
`define MAC_PARAMS_SVH

// Operand and result width
`define MAC_WIDTH 32
// Worst-case and early-exit iteration limits
`define MAC_MAX_CYCLES 16
`define MAC_SHORT_CYCLES 8
// Booth step consumes this many multiplier bits per clock
`define MAC_BITS_PER_STEP 2
// Program counter advance for each operand role
`define MAC_PC_ADV_MCAND 32'h0000000c
`define MAC_PC_ADV_MPLIER 32'h00000008
`define MAC_PC_ADV_ADDEND 32'h00000008
// Program counter field within the combined pc/status word
`define MAC_PC_FIELD_MASK 32'h03fffffc
// Register number of the program counter
`define MAC_PC_REG 4'hf

`endif

// ### logic/mac_pkg.sv
package mac_pkg;

   typedef enum logic [1:0] {
      st_idle,
      st_run,
      st_done
   } mac_state_e;

   // Issue request from decode
   typedef struct packed {
      logic accumulate;
      logic set_flags;
      logic [3:0] dest_reg;
      logic [3:0] multiplicand_reg;
      logic [3:0] multiplier_reg;
      logic [3:0] addend_reg;
   } mac_cmd_s;

   // Register file operand values
   typedef struct packed {
      logic [31:0] multiplicand;
      logic [31:0] multiplier;
      logic [31:0] addend;
      logic [31:0] pc_word;
   } mac_ops_s;

   // Condition flags
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } mac_flags_s;

endpackage

// ### logic/mac_operand_sel.sv
`timescale 1ns/100ps
`include "mac_params.svh"

// Picks a register value or the adjusted program counter for one operand
module mac_operand_sel (
   // Selection
   input wire logic [3:0] reg_num,
   input wire logic keep_status,
   input wire logic [31:0] advance,
   // Values
   input wire logic [31:0] reg_value,
   input wire logic [31:0] pc_word,
   // Result
   output logic [31:0] operand
);

   logic [31:0] pc_adv;

   // Advance only the address field so status bits stay intact
   assign pc_adv = (pc_word & ~`MAC_PC_FIELD_MASK)
                 | ((pc_word + advance) & `MAC_PC_FIELD_MASK);

   // Status bits stripped when the caller asks for a bare address
   assign operand = (reg_num != `MAC_PC_REG) ? reg_value :
                    keep_status ? pc_adv : (pc_adv & `MAC_PC_FIELD_MASK);

endmodule

// ### logic/mac_booth_step.sv
`timescale 1ns/100ps

// One radix-4 Booth step: multiple of the multiplicand for a bit triple
module mac_booth_step (
   // Inputs
   input wire logic [2:0] triple,
   input wire logic [31:0] mcand,
   // Partial product
   output logic [31:0] pp
);

   // Only the low 32 bits matter, so the wrap of -2x is harmless
   always_comb begin
      case (triple)
         3'h1, 3'h2: pp = mcand;
         3'h3: pp = {mcand[30:0], 1'b0};
         3'h4: pp = 32'h00000000 - {mcand[30:0], 1'b0};
         3'h5, 3'h6: pp = 32'h00000000 - mcand;
         default: pp = 32'h00000000;
      endcase
   end

endmodule

// ### tb/mac_regfile_model.sv
`timescale 1ns/100ps

// Register file of the issuing side: hands operand values to the unit
module mac_regfile_model (
   // Clock
   input wire logic clk,
   // Loading from the bench
   input wire logic ld_en,
   input wire logic [3:0] ld_num,
   input wire logic [31:0] ld_val,
   // Operand request
   input wire logic [31:0] pc_word,
   input wire mac_pkg::mac_cmd_s cmd,
   output mac_pkg::mac_ops_s ops
);
   logic [31:0] regs_ff [16];

   // Bench writes one register a clock
   always_ff @(posedge clk) begin
      if (ld_en) begin
         regs_ff[ld_num] <= ld_val;
      end
   end

   // Fetch is combinational so operands stand as long as the request does
   always_comb begin
      ops.multiplicand = regs_ff[cmd.multiplicand_reg];
      ops.multiplier = regs_ff[cmd.multiplier_reg];
      ops.addend = regs_ff[cmd.addend_reg];
      ops.pc_word = pc_word; // Slot 15 is raw; the unit must adjust it
   end
endmodule

// ### tb/multiply_accumulate_unit_tb.sv
`timescale 1ns/100ps

module multiply_accumulate_unit_tb;
   typedef struct packed {
      logic acc;
      logic sf;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic [31:0] r;
   } row_s;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic ld_en = 1'b0;
   logic [3:0] ld_num = 4'h0;
   logic [31:0] ld_val = 32'h0;
   logic [31:0] pc_word = 32'h8c001001;
   mac_pkg::mac_cmd_s cmd = '0;
   mac_pkg::mac_ops_s ops;
   mac_pkg::mac_flags_s flags_in = '0;
   mac_pkg::mac_flags_s flags_out;
   logic busy;
   logic done;
   logic flags_we;
   logic [3:0] dest_reg;
   logic [31:0] result;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   // Operands and the low word they give; signed, byte and wrapping cases
   row_s rows [9] = '{
      '{1'b0, 1'b1, 32'h3, 32'h5, 32'h0, 32'hf},
      '{1'b1, 1'b1, 32'hffffffff, 32'h7, 32'ha, 32'h3},
      '{1'b0, 1'b1, 32'hfffffffe, 32'hfffffffd, 32'h0, 32'h6},
      '{1'b0, 1'b1, 32'h10000, 32'h10000, 32'h0, 32'h0},
      '{1'b0, 1'b0, 32'h12, 32'h34, 32'h55, 32'h3a8}, // Addend ignored
      '{1'b1, 1'b1, 32'h80000000, 32'h1, 32'h80000000, 32'h0},
      '{1'b0, 1'b1, 32'h7fffffff, 32'h7fffffff, 32'h0, 32'h1},
      '{1'b0, 1'b1, 32'h2, 32'h40000000, 32'h0, 32'h80000000},
      '{1'b0, 1'b1, 32'h3, 32'hffff, 32'h0, 32'h2fffd} // Top bit of a 16-bit multiplier
   };

   multiply_accumulate_unit DUT (.clk(clk), .rstn(rstn), .start(start), .cmd(cmd),
      .ops(ops), .flags_in(flags_in), .busy(busy), .done(done), .dest_reg(dest_reg),
      .result(result), .flags_we(flags_we), .flags_out(flags_out));
   mac_regfile_model regs (.clk(clk), .ld_en(ld_en), .ld_num(ld_num), .ld_val(ld_val),
      .pc_word(pc_word), .cmd(cmd), .ops(ops));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // A hang counts as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      logic [31:0] v [3];
      v = '{a, b, c};
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         ld_en = 1'b1;
         ld_num = 4'(k + 1);
         ld_val = v[k];
      end
   endtask

   // Issue one operation; a poke retries start while busy with another destination
   task automatic issue(input logic acc, input logic sf, input logic [3:0] mc,
      input logic [3:0] ml, input logic [3:0] ad, input logic [31:0] b,
      input logic [31:0] r, input logic poke);
      int n;
      int lim;
      @(negedge clk);
      ld_en = 1'b0;
      check("busy idle", busy, 0);
      cmd = '{acc, sf, 4'h4, mc, ml, ad};
      start = 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         start = poke && n == 2;
         cmd.dest_reg = (poke && n == 2) ? 4'h5 : 4'h4;
         if (n == 1) check("busy run", busy, 1);
      end while (done !== 1'b1 && n < 20);
      // A short operand on either side allows the early exit
      lim = (b[31:16] == '0 || b[31:15] == '1
             || (mc != 4'hf && ops.multiplicand[31:16] == '0)) ? 9 : 17;
      check("cycles", 32'(n <= lim), 1);
      check("result", result, r);
      check("dest", dest_reg, 4);
      check("flags_we", flags_we, sf);
      if (sf) check("flags", flags_out, {r[31], r == 0, 1'b0, flags_in.v});
   endtask

   initial begin
      repeat (4) @(negedge clk);
      check("reset flags_we", flags_we, 0);
      rstn = 1'b1;
      foreach (rows[i]) begin
         flags_in = '{1'b1, 1'b1, 1'b1, i[0]};
         load(rows[i].a, rows[i].b, rows[i].c);
         issue(rows[i].acc, rows[i].sf, 4'h1, 4'h2, 4'h3, rows[i].b, rows[i].r, i == 6);
      end
      // Program counter operands, issued back to back
      load(32'h1, 32'h1, 32'h0);
      issue(1'b0, 1'b1, 4'hf, 4'h2, 4'h3, 32'h1, 32'h8c00100d, 1'b0);
      issue(1'b0, 1'b1, 4'h2, 4'hf, 4'h3, 32'h1008, 32'h1008, 1'b0);
      issue(1'b1, 1'b0, 4'h3, 4'h2, 4'hf, 32'h1, 32'h8c001009, 1'b0);
      // Reset in mid-operation, then a fresh run
      load(32'h1, 32'h2, 32'h1);
      @(negedge clk);
      ld_en = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      rstn = 1'b0;
      @(negedge clk);
      check("reset busy", busy, 0);
      check("reset result", result, 0);
      rstn = 1'b1;
      issue(1'b1, 1'b1, 4'h1, 4'h2, 4'h3, 32'h2, 32'h3, 1'b0);
      summarize();
   end
endmodule
